/* bench/sac_ctrl_properties.sv */
// port assertions for the conversion control block
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl_properties (
	input wire logic clk, rst_n, enable, convStart, secondaryStart, shutdown, busy, convDone,
	input wire logic doneFlag, doneIntEn, backgroundMode, doneIrq, winFlag, winIntEn, winIrq,
	input wire logic [2:0] gainSel, gainCode
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// cycles since the last start, saturating, for the spacing check
	logic [9:0] gapCnt;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			gapCnt <= 10'h3FF;
		end else if (convStart) begin
			gapCnt <= 10'h000;
		end else if (gapCnt != 10'h3FF) begin
			gapCnt <= gapCnt + 10'h001;
		end
	end
	// a conversion finishing while one is running
	sequence s_finish;
		busy && convDone && enable;
	endsequence
	start_space_a: assert property (convStart |-> gapCnt >= 10'(sac_pkg::MIN_PERIOD_CYC - 1))
		else $error("start spacing below limit");
	start_busy_a: assert property (convStart |-> busy)
		else $error("start without busy");
	shut_follow_a: assert property (shutdown == !enable)
		else $error("shutdown level wrong");
	off_nostart_a: assert property (!enable |=> !convStart)
		else $error("start during shutdown");
	start_gap_a: assert property (convStart |=> !convStart [*8])
		else $error("starts too close");
	sec_sync_a: assert property (secondaryStart |-> convStart)
		else $error("secondary start alone");
	done_latch_a: assert property (s_finish |-> ##[1:2] doneFlag)
		else $error("done flag not set");
	done_irq_a: assert property (doneIrq == (doneFlag && doneIntEn && !backgroundMode))
		else $error("done irq wrong");
	win_irq_a: assert property (winIrq == (winFlag && winIntEn))
		else $error("window irq wrong");
	gain_clamp_a: assert property (gainSel > 3'h5 |=> gainCode == 3'h5)
		else $error("gain not clamped");
endmodule : sac_ctrl_properties
bind sac_ctrl sac_ctrl_properties chk_u (
	.clk(clk), .rst_n(rst_n), .enable(enable), .convStart(convStart),
	.secondaryStart(secondaryStart), .shutdown(shutdown), .busy(busy), .convDone(convDone),
	.doneFlag(doneFlag), .doneIntEn(doneIntEn), .backgroundMode(backgroundMode),
	.doneIrq(doneIrq), .winFlag(winFlag), .winIntEn(winIntEn), .winIrq(winIrq),
	.gainSel(gainSel), .gainCode(gainCode)
);
`default_nettype wire

/* bench/sac_ctrl_tb.sv */
// self-checking bench for the conversion control block
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl_tb;
	import sac_pkg::*;
	// stimulus, all driven on the falling edge
	logic clk = 0, rst_n = 0, enable = 1, refDacSel = 0, leftJustify = 0, backgroundMode = 0;
	logic winOutside = 0, doneIntEn = 1, winIntEn = 1, syncSecondary = 1, convDone = 0;
	logic swStart = 0, tmr2Ovf = 0, tmr3Ovf = 0, extStart = 0, doneClr = 0, winClr = 0;
	logic [3:0] chanSel = 0, pairDiff = 0;
	logic [2:0] gainSel = 0;
	logic [1:0] trigSel = 0;
	logic [15:0] winGreater = 0, winLess = 16'hFFFF;
	logic [11:0] convData = 0;
	wire logic convStart, shutdown, diffMode, refFromDac, secondaryStart, busy;
	wire logic doneFlag, winFlag, doneIrq, winIrq;
	wire logic [3:0] muxPos, muxNeg;
	wire logic [2:0] gainCode;
	wire logic [7:0] resHigh, resLow;
	int n_fail = 0, n_checks = 0;
	sac_ctrl dut_u (
		.clk(clk), .rst_n(rst_n), .enable(enable), .chanSel(chanSel), .pairDiff(pairDiff),
		.gainSel(gainSel), .refDacSel(refDacSel), .leftJustify(leftJustify), .trigSel(trigSel),
		.backgroundMode(backgroundMode), .winOutside(winOutside), .doneIntEn(doneIntEn),
		.winIntEn(winIntEn), .syncSecondary(syncSecondary), .winGreater(winGreater),
		.winLess(winLess), .swStart(swStart), .tmr2Ovf(tmr2Ovf), .tmr3Ovf(tmr3Ovf),
		.extStart(extStart), .doneClr(doneClr), .winClr(winClr), .convDone(convDone),
		.convData(convData), .convStart(convStart), .shutdown(shutdown), .muxPos(muxPos),
		.muxNeg(muxNeg), .diffMode(diffMode), .gainCode(gainCode), .refFromDac(refFromDac),
		.secondaryStart(secondaryStart), .resHigh(resHigh), .resLow(resLow),
		.doneFlag(doneFlag), .winFlag(winFlag), .doneIrq(doneIrq), .winIrq(winIrq), .busy(busy)
	);
	always #10 clk = ~clk;
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : check
	// clear flags, fire one trigger, finish, then respect the start spacing
	task automatic conv(input logic [1:0] t);
		doneClr = 1; winClr = 1; trigSel = t;
		@(negedge clk) {doneClr, winClr} = 2'h0;
		{extStart, tmr3Ovf, tmr2Ovf, swStart} = 4'h1 << t;
		@(negedge clk) {extStart, tmr3Ovf, tmr2Ovf, swStart} = 4'h0;
		check(convStart, 1);
		check(busy, 1);
		check(secondaryStart, (t == 2'h0) && syncSecondary);
		repeat (5) @(negedge clk);
		convData = 12'hABC; convDone = 1;
		@(negedge clk) convDone = 0;
		@(negedge clk) check({doneFlag, busy}, 2'h2);
		repeat (500) @(negedge clk);
	endtask : conv
	task automatic t_route;
		chanSel = 4'h9; gainSel = 3'h7; refDacSel = 1;
		@(negedge clk) check(muxPos, CHAN_TEMP);
		check(gainCode, 3'h5);
		check({refFromDac, diffMode}, 2'h2);
		chanSel = 4'h3; pairDiff = 4'h2;
		@(negedge clk) check({muxPos, muxNeg, 7'h00, diffMode}, 16'h2301);
		$display("route test done");
	endtask : t_route
	task automatic t_refuse;
		enable = 0; trigSel = 2'h0; swStart = 1;
		@(negedge clk) check({shutdown, convStart, busy}, 3'h4);
		enable = 1; trigSel = 2'h1;
		@(negedge clk) check({shutdown, convStart, busy}, 3'h0);
		swStart = 0;
		$display("refuse test done");
	endtask : t_refuse
	task automatic t_result;
		conv(0);
		check({resHigh, resLow}, 16'h0ABC);
		check({doneIrq, winFlag, winIrq}, 3'h7);
		leftJustify = 1; winGreater = 16'hABC0; winLess = 16'hABC0;
		conv(1);
		check({resHigh, resLow}, 16'hABC0);
		check(winFlag, 1);
		winOutside = 1; backgroundMode = 1;
		conv(2);
		check({doneIrq, winFlag}, 2'h0);
		winGreater = 16'h0; winLess = 16'h1000;
		conv(3);
		check({doneIrq, winIrq}, 2'h1);
		backgroundMode = 0; doneIntEn = 0; winIntEn = 0; syncSecondary = 0;
		conv(0);
		check({doneIrq, winFlag, winIrq}, 3'h2);
		$display("result test done");
	endtask : t_result
	task automatic end_of_test;
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : end_of_test
	// watchdog well beyond the expected run of about 2560 cycles
	initial begin
		#200000 n_fail++;
		end_of_test();
	end
	initial begin
		repeat (12) @(negedge clk);
		rst_n = 1;
		check(gainCode, GAIN_RST);
		check({convStart, busy, doneFlag, winFlag}, 4'h0);
		t_route();
		t_refuse();
		t_result();
		end_of_test();
	end
endmodule : sac_ctrl_tb
`default_nettype wire

/* common/sac_pkg.sv */
// shared constants and types for the successive-approximation conversion control
`default_nettype none
package sac_pkg;
	// channel select codes: 0..7 external, 8..15 temperature sensor
	localparam int CHAN_W = 4;
	localparam logic [3:0] CHAN_TEMP = 4'h8;
	localparam int NUM_EXT = 8;
	// gain codes: 0=x0.5, 1=x1, 2=x2, 3=x4, 4=x8, 5=x16
	localparam int GAIN_W = 3;
	localparam logic [2:0] GAIN_MAX = 3'h5;
	localparam logic [2:0] GAIN_RST = 3'h1;
	// result widths and justification
	localparam int RES_W = 12;
	// trigger source select
	typedef enum logic [1:0] {
		SAC_TRIG_SW = 2'h0,
		SAC_TRIG_TMR2 = 2'h1,
		SAC_TRIG_TMR3 = 2'h2,
		SAC_TRIG_EXT = 2'h3
	} sac_trig_t;
	// throughput limit: 100 ksps at 50 MHz
	localparam int CLK_HZ = 50000000;
	localparam int MAX_SPS = 100000;
	localparam int MIN_PERIOD_CYC = (CLK_HZ + MAX_SPS - 1) / MAX_SPS;
	localparam int PER_W = 10;
endpackage : sac_pkg
`default_nettype wire

/* verilog/sac_ctrl.sv */
// conversion sequencing, result latch and window compare for the main converter
`timescale 1ns/1ps
`default_nettype none

module sac_ctrl
	import sac_pkg::*;
#(
	parameter int RES_BITS = 12
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// configuration
	input wire logic enable,
	input wire logic [sac_pkg::CHAN_W-1:0] chanSel,
	input wire logic [3:0] pairDiff,
	input wire logic [sac_pkg::GAIN_W-1:0] gainSel,
	input wire logic refDacSel,
	input wire logic leftJustify,
	input wire logic [1:0] trigSel,
	input wire logic backgroundMode,
	input wire logic winOutside,
	input wire logic doneIntEn,
	input wire logic winIntEn,
	input wire logic syncSecondary,
	input wire logic [15:0] winGreater,
	input wire logic [15:0] winLess,
	// start sources
	input wire logic swStart,
	input wire logic tmr2Ovf,
	input wire logic tmr3Ovf,
	input wire logic extStart,
	// flag clears
	input wire logic doneClr,
	input wire logic winClr,
	// analog side
	input wire logic convDone,
	input wire logic [sac_pkg::RES_W-1:0] convData,
	output logic convStart,
	output logic shutdown,
	output logic [sac_pkg::CHAN_W-1:0] muxPos,
	output logic [sac_pkg::CHAN_W-1:0] muxNeg,
	output logic diffMode,
	output logic [sac_pkg::GAIN_W-1:0] gainCode,
	output logic refFromDac,
	output logic secondaryStart,
	// results and status
	output logic [7:0] resHigh,
	output logic [7:0] resLow,
	output logic doneFlag,
	output logic winFlag,
	output logic doneIrq,
	output logic winIrq,
	output logic busy
);
	import sac_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [1:0] {SAC_IDLE, SAC_CONV} sac_state_t;
	sac_state_t stateReg, stateNext;
	logic [PER_W-1:0] rateCntReg;
	logic [15:0] resWordReg;
	logic doneReg, winReg, convStartReg, secStartReg;
	logic [2:0] gainReg;
	logic [3:0] posReg, negReg;
	logic diffReg, refReg;

	// ----------------------------------------
	// trigger and channel decode
	// ----------------------------------------
	// one trigger source selected at a time
	wire logic trigHit = (trigSel == SAC_TRIG_SW) ? swStart :
		(trigSel == SAC_TRIG_TMR2) ? tmr2Ovf :
		(trigSel == SAC_TRIG_TMR3) ? tmr3Ovf : extStart;
	wire logic rateOk = (rateCntReg == '0);
	wire logic startNow = enable && (stateReg == SAC_IDLE) && trigHit && rateOk;
	wire logic isTemp = (chanSel >= CHAN_TEMP);
	wire logic pairIsDiff = !isTemp && pairDiff[chanSel[2:1]];
	wire logic [3:0] posSel = isTemp ? CHAN_TEMP : (pairIsDiff ? {chanSel[3:1], 1'b0} : chanSel);
	wire logic [3:0] negSel = {chanSel[3:1], 1'b1};
	// gain codes beyond x16 clamp to x16
	wire logic [2:0] gainSat = (gainSel > GAIN_MAX) ? GAIN_MAX : gainSel;

	// ----------------------------------------
	// result alignment and window compare
	// ----------------------------------------
	wire logic [15:0] rawRes = {{(16-RES_W){1'b0}}, convData} >> (RES_W - RES_BITS);
	wire logic [15:0] alignRes = leftJustify ? (rawRes << (16 - RES_BITS)) : rawRes;
	// both bounds are inclusive
	// compare new word in register format as it is latched
	wire logic inWin = (alignRes >= winGreater) && (alignRes <= winLess);
	wire logic winHit = winOutside ? !inWin : inWin;
	// a completion outside a running conversion, or during shutdown, is ignored
	wire logic finish = (stateReg == SAC_CONV) && convDone && enable;

	// next state
	always_comb begin
		stateNext = stateReg;
		case (stateReg)
			SAC_IDLE: begin
				if (startNow) begin
					stateNext = SAC_CONV;
				end
			end
			SAC_CONV: begin
				if (!enable) begin
					stateNext = SAC_IDLE;
				end else if (convDone) begin
					stateNext = SAC_IDLE;
				end
			end
			default: stateNext = SAC_IDLE;
		endcase
	end

	// the counter reloads on each accepted start; triggers seen while it runs are dropped
	// state and rate counter
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stateReg <= SAC_IDLE;
			rateCntReg <= '0;
		end else begin
			stateReg <= stateNext;
			if (startNow) begin
				rateCntReg <= PER_W'(MIN_PERIOD_CYC - 1);
			end else if (!rateOk) begin
				rateCntReg <= rateCntReg - 1'b1;
			end
		end
	end

	// timer and external starts never pull the secondary converter along
	// start pulses, secondary follows software starts
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			convStartReg <= 1'b0;
			secStartReg <= 1'b0;
		end else begin
			convStartReg <= startNow;
			secStartReg <= startNow && syncSecondary && (trigSel == SAC_TRIG_SW);
		end
	end

	// negative input only matters while the pair is differential
	// analog configuration registered
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			posReg <= '0;
			negReg <= '0;
			diffReg <= 1'b0;
			gainReg <= GAIN_RST;
			refReg <= 1'b0;
		end else begin
			posReg <= posSel;
			negReg <= negSel;
			diffReg <= pairIsDiff;
			gainReg <= gainSat;
			refReg <= refDacSel;
		end
	end

	// result latch; done flag set wins over clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			resWordReg <= '0;
			doneReg <= 1'b0;
		end else begin
			if (finish) begin
				resWordReg <= alignRes;
			end
			doneReg <= finish | (doneReg & ~doneClr);
		end
	end

	// window flag; set wins over clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			winReg <= 1'b0;
		end else begin
			winReg <= (finish && winHit) | (winReg & ~winClr);
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign convStart = convStartReg;
	assign secondaryStart = secStartReg;
	// shutdown follows enable directly so the core powers down at once
	assign shutdown = !enable;
	assign muxPos = posReg;
	assign muxNeg = negReg;
	assign diffMode = diffReg;
	assign gainCode = gainReg;
	assign refFromDac = refReg;
	assign resHigh = resWordReg[15:8];
	assign resLow = resWordReg[7:0];
	assign doneFlag = doneReg;
	assign winFlag = winReg;
	// background mode silences the completion interrupt
	assign doneIrq = doneReg && doneIntEn && !backgroundMode;
	assign winIrq = winReg && winIntEn;
	assign busy = (stateReg == SAC_CONV);
endmodule : sac_ctrl

`default_nettype wire
